// ==== src/pesf_top.sv ====
// Sticky power event flags with mask, debouncers and interrupt request
//
// Chosen here: the placing of the registers and the strobed register port.
`include "pesf_defines.svh"

module pesf_top (
   input  wire logic                   sys_clk,
   input  wire logic                   nrst,
   input  wire pesf_pkg::pesf_bus_req_t bus_req,
   output      logic [31:0]            bus_rdata,
   input  wire logic                   wdt_event,
   input  wire logic                   warm_reset_n,
   input  wire logic                   adaptor_ok,
   input  wire logic                   rtc_wake,
   input  wire logic                   ring_indicate,
   input  wire logic                   on_key_n,
   input  wire logic [2:0]             pll_lock,
   output      logic                   irq
);
   import pesf_pkg::*;

   pesf_state_t st_r;
   pesf_state_t st_nxt;

   logic [3:0]  db_raw;
   logic [3:0]  db_rise;
   logic [9:0]  ev_set;
   logic [9:0]  ev_clr;
   logic        wr_status;
   logic        wr_mask;
   logic        rd_status;
   logic        rd_mask;

   function automatic logic addr_hit(input logic [7:0] a,
                                     input logic [7:0] ofs);
      addr_hit = (a == ofs);
   endfunction

   // Debouncer lanes, asserted level high: warm, power fail, ring, on key
   assign db_raw = {~on_key_n, ring_indicate, ~adaptor_ok, ~warm_reset_n};

   assign wr_status = bus_req.wr && addr_hit(bus_req.addr, `PESF_OFS_STATUS);
   assign wr_mask   = bus_req.wr && addr_hit(bus_req.addr, `PESF_OFS_MASK);
   assign rd_status = bus_req.rd && addr_hit(bus_req.addr, `PESF_OFS_STATUS);
   assign rd_mask   = bus_req.rd && addr_hit(bus_req.addr, `PESF_OFS_MASK);

   // Only written ones clear; reads and zeros leave flags alone
   assign ev_clr = wr_status ? bus_req.wdata[9:0] : 10'h000;

   always_comb begin
      st_nxt  = st_r;
      db_rise = 4'h0;
      // A level must stay away from the stable value for the full debounce
      // time; glitches shorter than that restart the count and are lost
      for (int i = 0; i < 4; i++) begin
         if (db_raw[i] == st_r.db_stable[i]) begin
            st_nxt.db_cnt[i] = 12'h000;
         end else if (st_r.db_cnt[i] == 12'(`PESF_DB_CYCLES - 1)) begin
            st_nxt.db_cnt[i]    = 12'h000;
            st_nxt.db_stable[i] = db_raw[i];
            db_rise[i]          = db_raw[i];
         end else begin
            st_nxt.db_cnt[i] = st_r.db_cnt[i] + 12'h001;
         end
      end

      ev_set = 10'h000;
      ev_set[`PESF_BIT_WDT]       = wdt_event;
      ev_set[`PESF_BIT_WARM]      = db_rise[0];
      ev_set[`PESF_BIT_PFAIL]     = db_rise[1];
      ev_set[`PESF_BIT_RTC]       = rtc_wake;
      ev_set[`PESF_BIT_RING]      = db_rise[2];
      ev_set[`PESF_BIT_ONKEY]     = db_rise[3];
      // Unlock is a level: the flag keeps setting while the PLL is out
      ev_set[`PESF_BIT_PLL_SYS]   = ~pll_lock[2];
      ev_set[`PESF_BIT_PLL_COMMS] = ~pll_lock[1];
      ev_set[`PESF_BIT_PLL_DISP]  = ~pll_lock[0];

      // A set in the clearing cycle wins so no event is lost
      st_nxt.status = (st_r.status & ~ev_clr) | ev_set;

      if (wr_mask) begin
         st_nxt.mask = bus_req.wdata[9:0];
      end

      if (rd_status) begin
         st_nxt.rdata = {22'h000000, st_r.status};
      end else if (rd_mask) begin
         st_nxt.rdata = {22'h000000, st_r.mask};
      end else begin
         st_nxt.rdata = 32'h00000000;
      end

      // Computed from next state so the registered level tracks the flags
      st_nxt.irq = |(st_nxt.status & st_nxt.mask);
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         st_r           <= '0;
         st_r.status    <= `PESF_STATUS_RST;
         st_r.mask      <= `PESF_MASK_RST;
         st_r.db_stable <= 4'h0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign bus_rdata = st_r.rdata;
   assign irq       = st_r.irq;

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!nrst);

   a_wdt_set: assert property (wdt_event |=> st_r.status[9])
      else $error("watchdog flag not set after event");

   a_warm_set: assert property (
      db_rise[0] |=> st_r.status[8])
      else $error("warm reset flag not set after debounced edge");

   a_pfail_set: assert property (
      db_rise[1] |=> st_r.status[7])
      else $error("power fail flag not set after debounced edge");

   a_rtc_set: assert property (rtc_wake |=> st_r.status[6])
      else $error("calendar wake flag not set after event");

   a_ring_set: assert property (db_rise[2] |=> st_r.status[5])
      else $error("ring indicate flag not set after debounced edge");

   a_onkey_set: assert property (db_rise[3] |=> st_r.status[4])
      else $error("on key flag not set after debounced edge");

   a_pll_sys_unlock: assert property (!pll_lock[2] |=> st_r.status[3])
      else $error("system pll unlock flag not set");

   a_pll_comms_unlock: assert property (!pll_lock[1] |=> st_r.status[2])
      else $error("comms pll unlock flag not set");

   a_pll_disp_unlock: assert property (!pll_lock[0] |=> st_r.status[1])
      else $error("display pll unlock flag not set");

   a_por_no_rise: assert property (!$rose(st_r.status[0]))
      else $error("power on flag rose without a reset");

   a_warm_debounced: assert property (
      $rose(st_r.status[8]) |-> $past(db_rise[0]))
      else $error("warm reset flag set without debounced edge");

   // Debouncers: a lane may only flip after its full count
   a_db_hold_warm: assert property (
      $changed(st_r.db_stable[0]) |-> $past(st_r.db_cnt[0]) == 12'(`PESF_DB_CYCLES - 1))
      else $error("warm reset debounce changed too early");

   a_db_hold_pfail: assert property (
      $changed(st_r.db_stable[1]) |-> $past(st_r.db_cnt[1]) == 12'(`PESF_DB_CYCLES - 1))
      else $error("power fail debounce changed too early");

   a_db_hold_ring: assert property (
      $changed(st_r.db_stable[2]) |-> $past(st_r.db_cnt[2]) == 12'(`PESF_DB_CYCLES - 1))
      else $error("ring indicate debounce changed too early");

   a_db_hold_onkey: assert property (
      $changed(st_r.db_stable[3]) |-> $past(st_r.db_cnt[3]) == 12'(`PESF_DB_CYCLES - 1))
      else $error("on key debounce changed too early");

   a_db_bound_warm: assert property (
      st_r.db_cnt[0] < 12'(`PESF_DB_CYCLES))
      else $error("warm reset debounce count overran");

   a_db_bound_pfail: assert property (
      st_r.db_cnt[1] < 12'(`PESF_DB_CYCLES))
      else $error("power fail debounce count overran");

   a_db_bound_ring: assert property (
      st_r.db_cnt[2] < 12'(`PESF_DB_CYCLES))
      else $error("ring indicate debounce count overran");

   a_db_bound_onkey: assert property (
      st_r.db_cnt[3] < 12'(`PESF_DB_CYCLES))
      else $error("on key debounce count overran");

   a_irq_level: assert property (
      irq == |(st_r.status & st_r.mask))
      else $error("interrupt level differs from masked flags");

   a_clear_w1: assert property (
      ((~st_r.status & $past(st_r.status) & ~$past(ev_clr)) == 10'h000))
      else $error("flag dropped without a written one");

   a_clear_done: assert property (
      (wr_status && bus_req.wdata[0]) |=> !st_r.status[0])
      else $error("power on flag not cleared by written one");

   a_rd_data: assert property (
      rd_status |=> bus_rdata == {22'h000000, $past(st_r.status)})
      else $error("status read data wrong");

   a_rd_mask_data: assert property (
      rd_mask |=> bus_rdata == {22'h000000, $past(st_r.mask)})
      else $error("mask read data wrong");

   a_rd_idle_zero: assert property (
      !(rd_status || rd_mask) |=> bus_rdata == 32'h00000000)
      else $error("read data not zero outside a read");

   a_rd_upper_zero: assert property (bus_rdata[31:10] == 22'h000000)
      else $error("unused read data bits not zero");

   a_mask_write: assert property (
      wr_mask |=> st_r.mask == $past(bus_req.wdata[9:0]))
      else $error("mask write did not land");

   a_mask_hold: assert property (
      !wr_mask |=> $stable(st_r.mask))
      else $error("mask changed without a write");

   a_irq_masked_off: assert property (
      (st_r.mask == 10'h000) |-> !irq)
      else $error("interrupt raised with every flag masked");

   // Clearing by a written one, unless the event lands in the same cycle
   a_wdt_clear: assert property (
      (wr_status && bus_req.wdata[9] && !wdt_event) |=> !st_r.status[9])
      else $error("watchdog flag not cleared");

   a_warm_clear: assert property (
      (wr_status && bus_req.wdata[8] && !db_rise[0]) |=> !st_r.status[8])
      else $error("warm reset flag not cleared");

   a_pfail_clear: assert property (
      (wr_status && bus_req.wdata[7] && !db_rise[1]) |=> !st_r.status[7])
      else $error("power fail flag not cleared");

   a_rtc_clear: assert property (
      (wr_status && bus_req.wdata[6] && !rtc_wake) |=> !st_r.status[6])
      else $error("calendar wake flag not cleared");

   a_ring_clear: assert property (
      (wr_status && bus_req.wdata[5] && !db_rise[2]) |=> !st_r.status[5])
      else $error("ring indicate flag not cleared");

   a_onkey_clear: assert property (
      (wr_status && bus_req.wdata[4] && !db_rise[3]) |=> !st_r.status[4])
      else $error("on key flag not cleared");

   a_pll_sys_clear: assert property (
      (wr_status && bus_req.wdata[3] && pll_lock[2]) |=> !st_r.status[3])
      else $error("system pll flag not cleared");

   a_pll_comms_clear: assert property (
      (wr_status && bus_req.wdata[2] && pll_lock[1]) |=> !st_r.status[2])
      else $error("comms pll flag not cleared");

   a_pll_disp_clear: assert property (
      (wr_status && bus_req.wdata[1] && pll_lock[0]) |=> !st_r.status[1])
      else $error("display pll flag not cleared");

   // A set in the clearing cycle must win
   a_wdt_set_wins: assert property (
      (wdt_event && wr_status && bus_req.wdata[9]) |=> st_r.status[9])
      else $error("watchdog event lost to a clear");

   a_rtc_set_wins: assert property (
      (rtc_wake && wr_status && bus_req.wdata[6]) |=> st_r.status[6])
      else $error("calendar wake event lost to a clear");

   a_sys_set_wins: assert property (
      (!pll_lock[2] && wr_status && bus_req.wdata[3]) |=> st_r.status[3])
      else $error("system pll unlock lost to a clear");

   a_comms_set_wins: assert property (
      (!pll_lock[1] && wr_status && bus_req.wdata[2]) |=> st_r.status[2])
      else $error("comms pll unlock lost to a clear");

   a_disp_set_wins: assert property (
      (!pll_lock[0] && wr_status && bus_req.wdata[1]) |=> st_r.status[1])
      else $error("display pll unlock lost to a clear");

   // Flags only rise on their own events
   a_wdt_cause: assert property (
      $rose(st_r.status[9]) |-> $past(wdt_event))
      else $error("watchdog flag set without event");

   a_pfail_cause: assert property (
      $rose(st_r.status[7]) |-> $past(db_rise[1]))
      else $error("power fail flag set without debounced edge");

   a_rtc_cause: assert property (
      $rose(st_r.status[6]) |-> $past(rtc_wake))
      else $error("calendar wake flag set without event");

   a_ring_cause: assert property (
      $rose(st_r.status[5]) |-> $past(db_rise[2]))
      else $error("ring indicate flag set without debounced edge");

   a_onkey_cause: assert property (
      $rose(st_r.status[4]) |-> $past(db_rise[3]))
      else $error("on key flag set without debounced edge");

   a_sys_cause: assert property (
      $rose(st_r.status[3]) |-> $past(!pll_lock[2]))
      else $error("system pll flag set while locked");

   a_comms_cause: assert property (
      $rose(st_r.status[2]) |-> $past(!pll_lock[1]))
      else $error("comms pll flag set while locked");

   a_disp_cause: assert property (
      $rose(st_r.status[1]) |-> $past(!pll_lock[0]))
      else $error("display pll flag set while locked");

   c_irq_raise: cover property (!irq ##1 irq);
   c_wdt_clear: cover property (
      st_r.status[9] ##1 (wr_status && bus_req.wdata[9]) ##1 !st_r.status[9]);
   c_warm_event: cover property (db_rise[0]);
   c_mask_read: cover property (rd_mask ##1 bus_rdata != 32'h00000000);
   c_set_on_clear: cover property (wdt_event && wr_status && bus_req.wdata[9]);

endmodule

// ==== src/pesf_defines.svh ====
// Offsets, field positions, reset values and timing counts of the flags
// Notes on behaviour
// - A watchdog event sets a sticky flag that reads 1 until software writes a 1 to it.
// - A warm reset event sets the sticky flag at bit 8, cleared by a written 1 or by reset.
// - An adaptor not-OK event sets the sticky power-fail flag at bit 7, cleared by a written 1.
// - A calendar wake-up from the real-time clock sets the flag at bit 6, cleared by a written 1.
// - A modem ring-indicate wake-up sets the flag at bit 5, cleared by a written 1.
// - An on-key event sets the flag at bit 4, cleared by a written 1.
// - Loss of lock on the system PLL sets bit 3, which stays 0 while lock holds.
// - Loss of lock on the comms PLL sets bit 2, which stays 0 while lock holds.
// - Loss of lock on the display PLL sets bit 1, which stays 0 while lock holds.
// - Bit 0 is set by power-on reset and stays set until software writes a 1 to it.
// - Warm reset, power fail, ring and on-key flags follow debounced inputs only.
// - The interrupt is a level, high while any flag is set with its mask bit enabled.
`ifndef PESF_DEFINES_SVH
`define PESF_DEFINES_SVH

`define PESF_OFS_STATUS     8'h00
`define PESF_OFS_MASK       8'h04

`define PESF_BIT_WDT        9
`define PESF_BIT_WARM       8
`define PESF_BIT_PFAIL      7
`define PESF_BIT_RTC        6
`define PESF_BIT_RING       5
`define PESF_BIT_ONKEY      4
`define PESF_BIT_PLL_SYS    3
`define PESF_BIT_PLL_COMMS  2
`define PESF_BIT_PLL_DISP   1
`define PESF_BIT_POR        0

`define PESF_STATUS_RST     10'h001
`define PESF_MASK_RST       10'h000

`define PESF_CLK_PERIOD_PS  5000
`define PESF_DB_TIME_NS     10000
`define PESF_DB_CYCLES      ((`PESF_DB_TIME_NS * 1000 + `PESF_CLK_PERIOD_PS - 1) / `PESF_CLK_PERIOD_PS)

`endif

// ==== src/pesf_pkg.sv ====
// Types shared by the power event status flag logic
package pesf_pkg;

   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } pesf_bus_req_t;

   typedef struct packed {
      logic [9:0]       status;
      logic [9:0]       mask;
      logic [3:0]       db_stable;
      logic [3:0][11:0] db_cnt;
      logic [31:0]      rdata;
      logic             irq;
   } pesf_state_t;

endpackage

// ==== dv/pesf_top_test.sv ====
// Register-level bench for the power event status flags
`include "pesf_defines.svh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin \
   bad_count++; $display("BAD %0t %h %h", $time, a, b); end end

module pesf_top_test;
   timeunit 1ns;
   timeprecision 100ps;
   import pesf_pkg::*;

   logic          sys_clk;
   logic          nrst;
   pesf_bus_req_t bus_req;
   logic [31:0]   bus_rdata;
   logic          wdt_event;
   logic          warm_reset_n;
   logic          adaptor_ok;
   logic          rtc_wake;
   logic          ring_indicate;
   logic          on_key_n;
   logic [2:0]    pll_lock;
   logic          irq;
   int            bad_count;
   int            total_checks;
   logic [31:0]   ebit [5] = '{32'h200, 32'h040, 32'h008, 32'h004, 32'h002};

   pesf_top u_pesf_top (.sys_clk(sys_clk), .nrst(nrst), .bus_req(bus_req),
      .bus_rdata(bus_rdata), .wdt_event(wdt_event),
      .warm_reset_n(warm_reset_n), .adaptor_ok(adaptor_ok),
      .rtc_wake(rtc_wake), .ring_indicate(ring_indicate),
      .on_key_n(on_key_n), .pll_lock(pll_lock), .irq(irq));

   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   task automatic finish_test();
      if (bad_count == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge sys_clk);
      bus_req.wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe, so sample there
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge sys_clk);
      bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge sys_clk);
      bus_req.rd <= 1'b0;
      #1;
      `CHK(bus_rdata, e)
   endtask

   task automatic raw(input logic on);
      warm_reset_n  <= ~on;
      adaptor_ok    <= ~on;
      ring_indicate <= on;
      on_key_n      <= ~on;
   endtask

   initial begin
      #100000;
      bad_count++;
      finish_test();
   end

   initial begin
      bus_req = '0;
      {wdt_event, rtc_wake, ring_indicate} = 3'h0;
      {warm_reset_n, adaptor_ok, on_key_n} = 3'h7;
      pll_lock = 3'h7;
      nrst = 1'b0;
      repeat (16) @(posedge sys_clk);
      nrst <= 1'b1;
      rd(`PESF_OFS_STATUS, 32'h001);
      rd(`PESF_OFS_STATUS, 32'h001);
      rd(`PESF_OFS_MASK, 32'h000);
      wr(`PESF_OFS_STATUS, 32'h000);
      rd(`PESF_OFS_STATUS, 32'h001);
      wr(`PESF_OFS_STATUS, 32'h001);
      rd(`PESF_OFS_STATUS, 32'h000);
      for (int i = 0; i < 5; i++) begin
         @(posedge sys_clk);
         case (i)
            0: wdt_event <= 1'b1;
            1: rtc_wake <= 1'b1;
            default: pll_lock[4-i] <= 1'b0;
         endcase
         @(posedge sys_clk);
         {wdt_event, rtc_wake} <= 2'h0;
         pll_lock <= 3'h7;
         rd(`PESF_OFS_STATUS, ebit[i]);
         wr(`PESF_OFS_STATUS, ebit[i]);
         rd(`PESF_OFS_STATUS, 32'h000);
      end
      // A glitch well short of the debounce time must leave no trace
      @(posedge sys_clk) raw(1'b1);
      repeat (100) @(posedge sys_clk);
      raw(1'b0);
      repeat (2100) @(posedge sys_clk);
      rd(`PESF_OFS_STATUS, 32'h000);
      @(posedge sys_clk) raw(1'b1);
      repeat (2010) @(posedge sys_clk);
      rd(`PESF_OFS_STATUS, 32'h1B0);
      @(posedge sys_clk) raw(1'b0);
      wr(`PESF_OFS_STATUS, 32'h1B0);
      rd(`PESF_OFS_STATUS, 32'h000);
      wr(`PESF_OFS_MASK, 32'h200);
      rd(`PESF_OFS_MASK, 32'h200);
      wr(8'h08, 32'h3FF);
      rd(8'h08, 32'h000);
      `CHK(irq, 1'b0)
      @(posedge sys_clk) wdt_event <= 1'b1;
      @(posedge sys_clk) wdt_event <= 1'b0;
      #1 `CHK(irq, 1'b1)
      wr(`PESF_OFS_MASK, 32'h000);
      #1 `CHK(irq, 1'b0)
      wr(`PESF_OFS_MASK, 32'h200);
      #1 `CHK(irq, 1'b1)
      wr(`PESF_OFS_STATUS, 32'h200);
      #1 `CHK(irq, 1'b0)
      // Event and clear in one cycle: the event must survive
      @(posedge sys_clk) begin
         bus_req <= '{addr: `PESF_OFS_STATUS, wdata: 32'h200, wr: 1'b1,
                      rd: 1'b0};
         wdt_event <= 1'b1;
      end
      @(posedge sys_clk) begin
         bus_req.wr <= 1'b0;
         wdt_event  <= 1'b0;
      end
      #1 `CHK(irq, 1'b1)
      rd(`PESF_OFS_STATUS, 32'h200);
      wr(`PESF_OFS_STATUS, 32'h200);
      rd(`PESF_OFS_STATUS, 32'h000);
      // A second reset in mid-run brings the power-on flag back
      @(posedge sys_clk) nrst <= 1'b0;
      repeat (4) @(posedge sys_clk);
      nrst <= 1'b1;
      rd(`PESF_OFS_STATUS, 32'h001);
      rd(`PESF_OFS_MASK, 32'h000);
      `CHK(irq, 1'b0)
      finish_test();
   end
endmodule
